/* rtl/vic_map.svh */
/*
 Address map, reset values, field positions and vector addresses of the
 interrupt controller. Assumes a 16-bit register address space.
*/
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH
`define VIC_A_REQ_LO 16'hffe0
`define VIC_A_REQ_HI 16'hffe1
`define VIC_A_MSK_LO 16'hffe4
`define VIC_A_MSK_HI 16'hffe5
`define VIC_A_EDG_LO 16'hffec
`define VIC_A_EDG_HI 16'hffed
`define VIC_A_KEY 16'hfff5
`define VIC_A_PSW 16'hfffe
`define VIC_A_SAVED 16'hfffd
`define VIC_RST_REQ 8'h00
`define VIC_RST_MSK 8'hff
`define VIC_RST_EDG 8'h00
`define VIC_RST_KEY 8'h00
`define VIC_RST_PSW 8'h02
`define VIC_IE_BIT 7
`define VIC_NSRC 14
`define VIC_NPIN 4
`define VIC_NKEY 4
`define VIC_VEC_NMI 16'h0004
`define VIC_VEC_PIN0 16'h0006
`define VIC_VEC_SRX 16'h000e
`define VIC_VEC_STX 16'h0012
`define VIC_LVL_PIN0 4'h1
`define VIC_LVL_SRX 4'h5
`define VIC_LVL_STX 4'h6
`endif

/* rtl/vic_pkg.sv */
/*
 Types shared by the interrupt controller modules.
 Assumes the map header supplies the numbers.
*/
package vic_pkg;
  typedef logic [3:0] vic_lvl_t;
  typedef logic [13:0] vic_src_t;
  typedef enum logic [1:0] {
    VIC_EDGE_FALL = 2'h0,
    VIC_EDGE_RISE = 2'h1,
    VIC_EDGE_BAD = 2'h2,
    VIC_EDGE_BOTH = 2'h3
  } vic_edge_t;
endpackage : vic_pkg

/* rtl/vic_arb_if.sv */
/*
 Carrier between the controller and its priority selector.
 Assumes one clock domain; the selector is purely combinational.
*/
`timescale 1ns/1ps
interface vic_arb_if;
  vic_pkg::vic_src_t pending;
  logic valid;
  vic_pkg::vic_lvl_t level;
  modport ctl (output pending, input valid, input level);
  modport arb (input pending, output valid, output level);
endinterface : vic_arb_if

/* rtl/vic_prio.sv */
/*
 Fixed priority selector: the lowest pending level wins.
 Assumes the pending vector is already masked; global enable is applied after selection.
*/
`timescale 1ns/1ps
module vic_prio (
  vic_arb_if.arb arb
);
  always_comb begin
    arb.valid = 1'b0;
    arb.level = 4'h0;
    for (int i = 13; i >= 0; i--) begin
      if (arb.pending[i]) begin
        arb.valid = 1'b1;
        arb.level = 4'(i);
      end
    end
  end
endmodule : vic_prio

/* rtl/vic_top.sv */
/*
 Vectored interrupt controller: request and mask flags, edge detection for
 pins and key return, global enable, fixed priority, vector output to the
 CPU core and standby release. Assumes source pulses from on-chip logic are
 one cycle wide on i_clock; pins are asynchronous and get synchronised.
*/
// The register addresses and the address-and-strobe port were chosen for this implementation.
// Operation
// - Non-maskable request is taken unconditionally and always beats maskable ones.
// - Watchdog overflow in mode 1 is the non-maskable source, vector 0004H.
// - Watchdog overflow in interval mode is maskable at level 0.
// - Each maskable request has its mask; every unmasked request raises standby release.
// - Simultaneous maskable requests are served in level order, 0 first.
// - Pin edges take levels 1 to 4, vectors 0006H to 000CH.
// - Serial receive end, either mode, is level 5, vector 000EH, one flag pair.
// - Serial transmit end is level 6, vector 0012H.
// - Timer matches use vectors 0016H, 0018H, 001AH at levels 8, 9, 10.
// - Conversion end is level 11, vector 001CH.
// - Key return is level 13, vector 0020H.
// - Fifteen sources in all, counting both watchdog forms.
// - Each maskable request has its own request and mask bit, serial receive shares one.
// - Global enable in the status word gates every maskable request.
// - Two edge select registers and one key return select register exist.
// - Flag set by its source, cleared on acceptance or reset; reset gives 00H.
// - Mask 0 enables, 1 disables; reset sets every mask bit.
// - On acceptance the status word is saved and global enable is cleared.
// - Edge field 00 falling, 01 rising, 11 both, 10 prohibited.
`timescale 1ns/1ps
`include "vic_map.svh"
module vic_top #(
  parameter int NPIN = `VIC_NPIN,
  parameter int NKEY = `VIC_NKEY
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Register port
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Watchdog
  input wire logic i_watchdog_overflow_irq,
  input wire logic i_wdt_mode1,
  // External pins
  input wire logic [NPIN-1:0] i_pin_edge_irq,
  input wire logic [NKEY-1:0] i_key_pin,
  // On-chip source pulses
  input wire logic i_serial_rx_done_irq,
  input wire logic i_serial_3wire_done_irq,
  input wire logic i_serial_tx_done_irq,
  input wire logic i_interval_tick_irq,
  input wire logic i_timer16_match_irq,
  input wire logic i_timer8a_match_irq,
  input wire logic i_timer8b_match_irq,
  input wire logic i_adc_done_irq,
  input wire logic i_watch_tick_irq,
  // CPU core
  input wire logic i_ack,
  output logic o_irq_req,
  output logic o_nmi,
  output logic [15:0] o_vector,
  output logic [7:0] o_psw_saved,
  output logic o_standby_release
);
  // The edge select layout serves exactly four pins; key detection folds at most eight.
  if (NPIN != 4 || NKEY < 1 || NKEY > 8) begin : g_bad_param
    $error("vic_top: unsupported pin count");
  end

  function automatic logic [15:0] vec_of(input vic_pkg::vic_lvl_t lvl);
    logic [15:0] v;
    v = `VIC_VEC_NMI;
    if (lvl >= `VIC_LVL_STX) begin
      v = `VIC_VEC_STX + 16'({lvl - `VIC_LVL_STX, 1'b0});
    end else if (lvl == `VIC_LVL_SRX) begin
      v = `VIC_VEC_SRX;
    end else if (lvl >= `VIC_LVL_PIN0) begin
      v = `VIC_VEC_PIN0 + 16'({lvl - `VIC_LVL_PIN0, 1'b0});
    end
    return v;
  endfunction : vec_of

  function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
                                    input logic prev);
    logic h;
    unique case (vic_pkg::vic_edge_t'(sel))
      vic_pkg::VIC_EDGE_FALL: h = prev & ~cur;
      vic_pkg::VIC_EDGE_RISE: h = ~prev & cur;
      vic_pkg::VIC_EDGE_BOTH: h = prev ^ cur;
      vic_pkg::VIC_EDGE_BAD: h = 1'b0;
    endcase
    return h;
  endfunction : edge_hit

  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pins pass two flip-flops; a third stage holds the previous level.
  logic [NPIN-1:0] pin_s1_reg, pin_s2_reg, pin_old_reg;
  logic [NKEY-1:0] key_s1_reg, key_s2_reg;
  logic key_old_reg;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_old_reg <= '0;
      key_s1_reg <= '1;
      key_s2_reg <= '1;
      key_old_reg <= 1'b1;
    end else begin
      pin_s1_reg <= i_pin_edge_irq;
      pin_s2_reg <= pin_s1_reg;
      pin_old_reg <= pin_s2_reg;
      key_s1_reg <= i_key_pin;
      key_s2_reg <= key_s1_reg;
      key_old_reg <= &key_s2_reg;
    end
  end

  logic [7:0] req_lo, req_hi, msk_lo, msk_hi;
  logic [7:0] edge_lo_reg, edge_hi_reg, key_sel_reg, psw_reg;
  vic_pkg::vic_src_t req_flag_reg, msk_flag_reg, hit, sw_set, sw_clr;
  vic_pkg::vic_src_t hw_clr;
  logic nmi_flag_reg;
  logic [NPIN-1:0] pin_hit;
  logic wdt_nmi_hit, key_hit, ie;

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      logic [1:0] sel;
      if (g == NPIN - 1) begin : g_hi
        assign sel = edge_hi_reg[1:0];
      end else begin : g_lo
        assign sel = edge_lo_reg[2*g+2 +: 2];
      end
      assign pin_hit[g] = edge_hit(sel, pin_s2_reg[g], pin_old_reg[g]);
    end
  endgenerate

  // A low level on any selected key pin masks edges on the others.
  assign key_hit = key_sel_reg[0] & key_old_reg & ~(&key_s2_reg);
  assign wdt_nmi_hit = i_watchdog_overflow_irq & i_wdt_mode1;

  assign hit = {
    key_hit,
    i_watch_tick_irq,
    i_adc_done_irq,
    i_timer8b_match_irq,
    i_timer8a_match_irq,
    i_timer16_match_irq,
    i_interval_tick_irq,
    i_serial_tx_done_irq,
    i_serial_rx_done_irq | i_serial_3wire_done_irq,
    pin_hit,
    i_watchdog_overflow_irq & ~i_wdt_mode1
  };

  assign req_lo = {req_flag_reg[6], 1'b0, req_flag_reg[5:0]};
  assign req_hi = {1'b0, req_flag_reg[13:7]};
  assign msk_lo = {msk_flag_reg[6], 1'b1, msk_flag_reg[5:0]};
  assign msk_hi = {1'b1, msk_flag_reg[13:7]};
  assign ie = psw_reg[`VIC_IE_BIT];

  vic_arb_if arb_if ();
  vic_prio vic_prio_inst (
    .arb(arb_if.arb)
  );
  assign arb_if.pending = req_flag_reg & ~msk_flag_reg;

  logic serve_nmi, serve_mask, accept;
  assign serve_nmi = nmi_flag_reg;
  assign serve_mask = arb_if.valid & ie & ~nmi_flag_reg;
  assign accept = i_ack & o_irq_req;

  // Held copy of what the core sees, so the ack clears exactly that flag.
  logic held_nmi_reg;
  vic_pkg::vic_lvl_t held_lvl_reg;

  always_comb begin
    sw_set = '0;
    sw_clr = '0;
    if (i_wr && i_addr == `VIC_A_REQ_LO) begin
      sw_set[6:0] = {i_wdata[7], i_wdata[5:0]};
      sw_clr[6:0] = ~{i_wdata[7], i_wdata[5:0]};
    end else if (i_wr && i_addr == `VIC_A_REQ_HI) begin
      sw_set[13:7] = i_wdata[6:0];
      sw_clr[13:7] = ~i_wdata[6:0];
    end
    hw_clr = '0;
    if (accept && !held_nmi_reg) begin
      hw_clr[held_lvl_reg] = 1'b1;
    end
  end

  // Request flags: a source event in the clearing cycle wins.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      req_flag_reg <= {2{7'(`VIC_RST_REQ)}};
    end else begin
      req_flag_reg <= ((req_flag_reg & ~sw_clr & ~hw_clr) | sw_set) | hit;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      nmi_flag_reg <= 1'b0;
    end else if (wdt_nmi_hit) begin
      nmi_flag_reg <= 1'b1;
    end else if (accept && held_nmi_reg) begin
      nmi_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      msk_flag_reg <= {2{7'(`VIC_RST_MSK)}};
    end else if (i_wr && i_addr == `VIC_A_MSK_LO) begin
      msk_flag_reg[6:0] <= {i_wdata[7], i_wdata[5:0]};
    end else if (i_wr && i_addr == `VIC_A_MSK_HI) begin
      msk_flag_reg[13:7] <= i_wdata[6:0];
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      edge_lo_reg <= `VIC_RST_EDG;
      edge_hi_reg <= `VIC_RST_EDG;
      key_sel_reg <= `VIC_RST_KEY;
    end else if (i_wr) begin
      if (i_addr == `VIC_A_EDG_LO) begin
        edge_lo_reg <= {i_wdata[7:2], 2'h0};
      end
      if (i_addr == `VIC_A_EDG_HI) begin
        edge_hi_reg <= {6'h0, i_wdata[1:0]};
      end
      if (i_addr == `VIC_A_KEY) begin
        key_sel_reg <= {7'h0, i_wdata[0]};
      end
    end
  end

  // Acceptance beats a software write to the status word in the same cycle.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      psw_reg <= `VIC_RST_PSW;
      o_psw_saved <= `VIC_RST_PSW;
    end else if (accept) begin
      o_psw_saved <= psw_reg;
      psw_reg[`VIC_IE_BIT] <= 1'b0;
    end else if (i_wr && i_addr == `VIC_A_PSW) begin
      psw_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_irq_req <= 1'b0;
      o_nmi <= 1'b0;
      o_vector <= `VIC_VEC_NMI;
      held_nmi_reg <= 1'b0;
      held_lvl_reg <= 4'h0;
    end else begin
      o_irq_req <= (serve_nmi | serve_mask) & ~accept;
      // Dropped with the request on acceptance, so it never outlives the presentation.
      o_nmi <= serve_nmi & ~accept;
      held_nmi_reg <= serve_nmi;
      held_lvl_reg <= arb_if.level;
      o_vector <= serve_nmi ? `VIC_VEC_NMI : vec_of(arb_if.level);
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_standby_release <= 1'b0;
    end else begin
      o_standby_release <= nmi_flag_reg | (|arb_if.pending);
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        `VIC_A_REQ_LO: o_rdata <= req_lo;
        `VIC_A_REQ_HI: o_rdata <= req_hi;
        `VIC_A_MSK_LO: o_rdata <= msk_lo;
        `VIC_A_MSK_HI: o_rdata <= msk_hi;
        `VIC_A_EDG_LO: o_rdata <= edge_lo_reg;
        `VIC_A_EDG_HI: o_rdata <= edge_hi_reg;
        `VIC_A_KEY: o_rdata <= key_sel_reg;
        `VIC_A_PSW: o_rdata <= psw_reg;
        `VIC_A_SAVED: o_rdata <= o_psw_saved;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule : vic_top

/* test/vic_cpu_model.sv */
/* CPU core stand-in that acknowledges presented interrupts.
   Assumes the controller's clock and registered request output. */
`timescale 1ns/1ps
module vic_cpu_model #(
  parameter int DELAY = 2
) (
  // Controller side
  input wire logic i_clock,
  input wire logic i_irq_req,
  output logic o_ack
);
  int cnt = 0;
  logic ack_reg = 1'b0;
  assign o_ack = ack_reg;
  // One-cycle pulses only, so one request is never taken twice.
  always @(posedge i_clock) begin
    ack_reg <= 1'b0;
    if (!i_irq_req || ack_reg) begin
      cnt <= 0;
    end else if (cnt == DELAY) begin
      ack_reg <= 1'b1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : vic_cpu_model

/* test/vic_top_properties.sv */
/* Port-level checks of the interrupt controller.
   Assumes binding into vic_top. */
`timescale 1ns/1ps
module vic_top_properties (
  // Observed ports
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_ack,
  input wire logic i_watchdog_overflow_irq,
  input wire logic i_wdt_mode1,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq_req,
  input wire logic o_nmi,
  input wire logic [15:0] o_vector,
  input wire logic o_standby_release
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  property p_nmi_vec; o_nmi |-> o_irq_req && o_vector == 16'h0004; endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector wrong");
  property p_nmi_take;
    i_watchdog_overflow_irq && i_wdt_mode1 && !o_irq_req ##1 !i_ack |-> ##1 o_irq_req && o_nmi;
  endproperty
  a_nmi_take: assert property (p_nmi_take) else $error("nmi not presented");
  property p_std_nmi;
    i_watchdog_overflow_irq && i_wdt_mode1 && !o_irq_req |-> ##2 o_standby_release;
  endproperty
  a_std_nmi: assert property (p_std_nmi) else $error("no standby release");
  property p_req_std; o_irq_req |-> o_standby_release; endproperty
  a_req_std: assert property (p_req_std) else $error("request without release");
  property p_ack_drop; o_irq_req && i_ack |=> !o_irq_req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
  property p_hold; o_irq_req && !i_ack |=> o_irq_req; endproperty
  a_hold: assert property (p_hold) else $error("request dropped unaccepted");
  property p_vec_rng;
    o_irq_req |-> !o_vector[0] && o_vector != 16'h0010 && o_vector inside {[16'h0004:16'h0020]};
  endproperty
  a_vec_rng: assert property (p_vec_rng) else $error("vector outside table");
  property p_req_resv; i_rd && i_addr == 16'hffe0 |=> !o_rdata[6]; endproperty
  a_req_resv: assert property (p_req_resv) else $error("reserved request bit set");
  property p_msk_resv; i_rd && i_addr == 16'hffe4 |=> o_rdata[6]; endproperty
  a_msk_resv: assert property (p_msk_resv) else $error("reserved mask bit clear");
endmodule : vic_top_properties
bind vic_top vic_top_properties vic_top_properties_inst (.i_clock, .i_nrst, .i_addr, .i_rd,
  .i_ack, .i_watchdog_overflow_irq, .i_wdt_mode1, .o_rdata, .o_irq_req, .o_nmi, .o_vector,
  .o_standby_release);

/* test/vectored_interrupt_controller_bench.sv */
/* Self-checking bench of the interrupt controller.
   Assumes vic_top, the CPU model and the bound checker. */
`timescale 1ns/1ps
module vectored_interrupt_controller_bench;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wdt = 1'b0;
  logic mode1 = 1'b0;
  logic [3:0] pin = 4'h0;
  logic [3:0] key = 4'hf;
  logic [8:0] src = 9'h000;
  logic ack, irq, nmi, stby;
  logic [7:0] rdata, psaved;
  logic [15:0] vec;
  logic [15:0] order [9] = '{16'h0004, 16'h000e, 16'h0012, 16'h0014, 16'h0016, 16'h0018,
    16'h001a, 16'h001c, 16'h001e};
  int miscompares = 0;
  int n_compared = 0;
  always #25 i_clock = ~i_clock;
  vic_top vic_top_inst (.i_clock, .i_nrst, .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_watchdog_overflow_irq(wdt), .i_wdt_mode1(mode1),
    .i_pin_edge_irq(pin), .i_key_pin(key), .i_serial_rx_done_irq(src[0]),
    .i_serial_3wire_done_irq(src[1]), .i_serial_tx_done_irq(src[2]),
    .i_interval_tick_irq(src[3]), .i_timer16_match_irq(src[4]), .i_timer8a_match_irq(src[5]),
    .i_timer8b_match_irq(src[6]), .i_adc_done_irq(src[7]), .i_watch_tick_irq(src[8]),
    .i_ack(ack), .o_irq_req(irq), .o_nmi(nmi), .o_vector(vec), .o_psw_saved(psaved),
    .o_standby_release(stby));
  vic_cpu_model vic_cpu_model_inst (.i_clock, .i_irq_req(irq), .o_ack(ack));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rreg
  task automatic pulse(input logic [8:0] s, input logic w);
    @(posedge i_clock);
    src <= s;
    wdt <= w;
    @(posedge i_clock);
    src <= 9'h000;
    wdt <= 1'b0;
  endtask : pulse
  // Waits for a presentation, checks it, then lets the CPU model accept it.
  task automatic take(input logic [15:0] exp, input logic exp_nmi);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    chk({irq, nmi, vec[13:0]}, {1'b1, exp_nmi, exp[13:0]});
    while (irq === 1'b1 && n < 80) begin
      @(posedge i_clock);
      #1;
      n++;
    end
  endtask : take
  task automatic quiet(input logic exp_stby);
    repeat (8) @(posedge i_clock);
    #1;
    chk({14'h0, irq, stby}, {14'h0, 1'b0, exp_stby});
  endtask : quiet
  task automatic t_reset();
    rreg(16'hffe0, 8'h00);
    rreg(16'hffe1, 8'h00);
    rreg(16'hffe4, 8'hff);
    rreg(16'hffe5, 8'hff);
    rreg(16'hfffe, 8'h02);
  endtask : t_reset
  task automatic t_masked();
    wreg(16'hfffe, 8'h82);
    pulse(9'h004, 1'b0);
    quiet(1'b0);
    rreg(16'hffe0, 8'h80);
    wreg(16'hffe0, 8'h00);
  endtask : t_masked
  task automatic t_order();
    wreg(16'hffe4, 8'h00);
    wreg(16'hffe5, 8'h00);
    pulse(9'h1fd, 1'b1);
    foreach (order[i]) begin
      take(order[i], 1'b0);
      if (i < 8) wreg(16'hfffe, 8'h82);
    end
    rreg(16'hfffe, 8'h02);
    rreg(16'hfffd, 8'h82);
    chk({8'h00, psaved}, 16'h0082);
    rreg(16'hffe1, 8'h00);
  endtask : t_order
  task automatic t_gate();
    pulse(9'h080, 1'b0);
    quiet(1'b1);
    wreg(16'hfffe, 8'h82);
    take(16'h001c, 1'b0);
    pulse(9'h002, 1'b0);
    wreg(16'hfffe, 8'h82);
    take(16'h000e, 1'b0);
  endtask : t_gate
  task automatic t_nmi();
    wreg(16'hfffe, 8'h82);
    @(posedge i_clock);
    mode1 <= 1'b1;
    pulse(9'h080, 1'b1);
    take(16'h0004, 1'b1);
    wreg(16'hfffe, 8'h82);
    take(16'h001c, 1'b0);
    @(posedge i_clock);
    mode1 <= 1'b0;
  endtask : t_nmi
  task automatic t_edges();
    wreg(16'hffec, 8'hc4);
    wreg(16'hffed, 8'h02);
    wreg(16'hfff5, 8'h01);
    wreg(16'hfffe, 8'h82);
    @(posedge i_clock);
    pin <= 4'hf;
    take(16'h0006, 1'b0);
    wreg(16'hfffe, 8'h82);
    take(16'h000a, 1'b0);
    @(posedge i_clock);
    pin <= 4'h0;
    wreg(16'hfffe, 8'h82);
    take(16'h0008, 1'b0);
    wreg(16'hfffe, 8'h82);
    take(16'h000a, 1'b0);
    wreg(16'hfffe, 8'h82);
    key <= 4'he;
    take(16'h0020, 1'b0);
    wreg(16'hfffe, 8'h82);
    quiet(1'b0);
    wreg(16'hffed, 8'h03);
    pin <= 4'h8;
    take(16'h000c, 1'b0);
  endtask : t_edges
  task automatic print_verdict();
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #(50 * 5000);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clock);
    t_reset();
    t_masked();
    t_order();
    t_gate();
    t_nmi();
    t_edges();
    print_verdict();
  end
endmodule : vectored_interrupt_controller_bench
